// [bench/tb.sv]
// bench top: ahb master, scan strobes, one task per scenario.
// assumes short timer steps and the pin model on input_pins.
`default_nettype none
module tb import tcu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLOW = 50;
    localparam int FAST = 5;
    logic        clk, rstn, hsel, hwrite, hrdy, hresp, ten, tsel, cin, rtim, rbt_seen;
    logic        ready, busy, lamp, rbt;
    logic [4:0]  stb;
    logic [1:0]  htrans;
    logic [2:0]  iidx;
    logic [5:0]  tidx, cidx;
    logic [6:0]  ridx;
    logic [7:0]  pins_in, image, latch;
    logic [15:0] tpc, tpd, cpre;
    logic [31:0] haddr, hwdata, hrdata, rd, hw0, hw1;
    logic [63:0] tcon, ccon;
    int          errors, cmp_count, cyc;
    tcu_pin_model pins (.clk(clk), .input_pins(pins_in));
    tcu_timer_counter #(.SLOW_STEP_CYC(SLOW), .FAST_STEP_CYC(FAST)) dut (
        .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .input_pins(pins_in), .scan_start(stb[0]), .irq_service(stb[1]),
        .irq_index(iidx), .tmr_exec(stb[2]), .tmr_index(tidx), .tmr_enable(ten),
        .tmr_preset_sel(tsel), .tmr_preset_const(tpc), .tmr_preset_dreg(tpd),
        .cnt_exec(stb[3]), .cnt_index(cidx), .cnt_input(cin), .cnt_preset(cpre),
        .rst_exec(stb[4]), .rst_timer(rtim), .rst_index(ridx), .timer_contact(tcon),
        .counter_contact(ccon), .hw_pulse_counter_0(hw0), .hw_pulse_counter_1(hw1),
        .input_image(image), .irq_input_latch(latch), .periph_ready_flag(ready),
        .periph_init_busy(busy), .fault_lamp_out(lamp), .sys_reboot(rbt)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the reboot strobe lasts one cycle, so it is caught here rather than polled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rbt === 1'b1) rbt_seen <= 1'b1;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic check(input string name, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic fire(input int k);
        stb[k] <= 1'b1;
        tick(1);
        stb[k] <= 1'b0;
        tick(1);
    endtask : fire
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do tick(1); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do tick(1); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic tmr(input logic [5:0] i, input logic en, sel, input logic [15:0] p);
        tidx <= i;
        ten  <= en;
        tsel <= sel;
        tpc  <= sel ? 16'h0 : p;
        tpd  <= p;
        fire(2);
    endtask : tmr
    task automatic wait_ready;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) tick(1);
        check("ready", 1, ready);
    endtask : wait_ready
    task automatic set_cfg(input logic [3:0] c);
        ahb(1'b1, TCU_OFS_CFG, {28'h0, c});
        ahb(1'b1, TCU_OFS_FLAGS, 32'h0);
        tick(1);
        check("init busy", 1, busy);
        wait_ready();
    endtask : set_cfg
    task automatic t_flags;
        ahb(1'b0, TCU_OFS_CFG, 32'h0);
        check("cfg reset", TCU_CFG_RST, rd);
        ahb(1'b0, 8'h40, 32'h0);
        check("unmapped", 0, rd);
        check("hresp", 0, hresp);
        ahb(1'b1, TCU_OFS_FLAGS, 32'h3);
        tick(1);
        check("lamp on", 1, lamp);
        ahb(1'b1, TCU_OFS_FLAGS, 32'h5);
        tick(1);
        check("lamp off", 0, lamp);
        set_cfg(4'h0);
        check("reboot", 1, rbt_seen);
        ahb(1'b0, TCU_OFS_FLAGS, 32'h0);
        check("flags", 32'h1, rd);
        $display("flags test done");
    endtask : t_flags
    task automatic t_irq;
        fire(0);
        pins.drive(8'h10);
        iidx <= 3'h4;
        fire(1);
        check("latch", 8'h10, latch);
        check("image held", 8'h00, image);
        fire(0);
        pins.drive(8'h00);
        tick(2);
        check("image", 8'h10, image);
        $display("interrupt latch test done");
    endtask : t_irq
    task automatic t_hwc;
        logic [11:0] r0 = 12'hb4a;
        logic [11:0] f0 = 12'hd8c;
        logic [11:0] r1 = 12'h1d0;
        logic [11:0] f1 = 12'he20;
        logic [15:0] q  = 16'h1e2d;
        for (int c = 0; c < 12; c++) begin
            set_cfg(4'(c));
            pins.drive(8'h03);
            tick(5);
            check("c0 rise", 32'(r0[c]), hw0);
            check("c1 rise", 32'(r1[c]), hw1);
            fire(0);
            check("image", {6'h0, 1'(c < 4), 1'(c == 0 || c == 4 || c == 5)}, image);
            pins.drive(8'h00);
            tick(5);
            check("c0 both", 32'(r0[c]) + 32'(f0[c]), hw0);
            check("c1 both", 32'(r1[c]) + 32'(f1[c]), hw1);
        end
        ridx <= 7'd64;
        fire(4);
        check("c0 reset", 0, hw0);
        ahb(1'b0, TCU_OFS_HWC1, 32'h0);
        check("c1 read", 1, rd);
        set_cfg(4'hc);
        ahb(1'b0, TCU_OFS_ACTIVE, 32'h0);
        check("active cfg", 32'hc, rd);
        for (int i = 0; i < 8; i++) begin
            pins.drive({6'h0, q[2*i +: 2]});
            tick(4);
            if (i == 3) check("quad up", 4, hw0);
        end
        check("quad down", 0, hw0);
        $display("pin counter test done");
    endtask : t_hwc
    task automatic t_tmr;
        tmr(6'd0, 1'b1, 1'b0, 16'd3);
        tick(2 * SLOW - 4);
        check("t0 early", 0, tcon[0]);
        for (int i = 0; i < SLOW + 10 && tcon[0] !== 1'b1; i++) tick(1);
        check("t0 done", 1, tcon[0]);
        tmr(6'd0, 1'b0, 1'b0, 16'd3);
        check("t0 off", 0, tcon[0]);
        tmr(6'd62, 1'b1, 1'b1, 16'd2);
        for (int i = 0; i < 3 * FAST && tcon[62] !== 1'b1; i++) tick(1);
        check("t62 done", 1, tcon[62]);
        tmr(6'd62, 1'b0, 1'b1, 16'd2);
        tick(3 * FAST);
        check("t62 kept", 1, tcon[62]);
        rtim <= 1'b1;
        ridx <= 7'd62;
        fire(4);
        check("t62 reset", 0, tcon[62]);
        $display("timer test done");
    endtask : t_tmr
    task automatic t_cnt;
        logic [9:0] exp = 10'h218;
        cidx <= 6'd5;
        cpre <= 16'd2;
        rtim <= 1'b0;
        ridx <= 7'd5;
        for (int i = 0; i < 10; i++) begin
            cin <= i[0];
            fire(3);
            if (i == 5) fire(4);
            check("c5 contact", 32'(exp[i]), ccon[5]);
        end
        $display("counter test done");
    endtask : t_cnt
    initial begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata, stb, iidx, rbt_seen} = '0;
        {tidx, ten, tsel, tpc, tpd, cidx, cin, cpre, rtim, ridx} = '0;
        tick(8);
        rstn <= 1'b1;
        wait_ready();
        t_flags();
        t_irq();
        t_hwc();
        t_tmr();
        t_cnt();
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// [bench/tcu_pin_model.sv]
// pin model: field side of the discrete inputs, slow levels only.
// assumes calls come just after a rising edge of clk.
`default_nettype none
module tcu_pin_model (
    input  wire logic       clk,
    output var  logic [7:0] input_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial input_pins = 8'h00;
    // level lands on the next edge, so two changes never share a cycle
    task automatic drive(input logic [7:0] v);
        @(posedge clk);
        input_pins <= v;
    endtask : drive
endmodule : tcu_pin_model
`default_nettype wire

// [design/tcu_pkg.sv]
// package for the plc timer / counter unit: register map, field layout, timing constants.
// assumes a 50 MHz system clock and one ahb-lite master reaching the register file.
//
// Overview of operation
// - each interrupt input latch captures its pin when that input's interrupt is serviced.
// - servicing an interrupt never changes the scan input image.
// - peripheral-ready rises when peripheral init finishes and then stays high until software clears it.
// - clearing peripheral-ready reruns peripheral init, applying a changed pin configuration.
// - fault-lamp flag set lights the front panel fault lamp; clear turns it off.
// - reboot request set, then peripheral-ready cleared, causes a full reboot.
// - timer delay is preset times step; timers 0-47 step 100 ms, 48-63 10 ms.
// - while enabled a timer counts steps; contact closes once count reaches preset.
// - general timer disabled clears its value and opens its contact.
// - timers 46, 47, 62, 63 keep accumulated time when disabled.
// - timer preset comes from an immediate constant or a data register value.
// - a timer starts counting as soon as its timer instruction executes.
// - general counter adds one per rising edge of its input; closes at preset.
// - a general counter at its preset ignores further pulses and holds.
// - counter reset zeroes the current value and opens the contact.
// - hardware counters never stop at a threshold; they count pin edges directly.
// - configuration 0 leaves inputs 0 and 1 as ordinary discrete inputs.
// - configurations 1-3 count input 0 rising, falling, both on counter 0.
// - configurations 4, 5 count input 1 rising, falling on counter 1.
// - configurations 6-11 route both inputs with the tabled edge choices.
// - configuration 12 runs inputs 0 and 1 as quadrature into counter 0.
// - every counter value is held as 32 bits.
// - input image is sampled at scan start and held through the scan.

`default_nettype none

package tcu_pkg;

    localparam int          TCU_CLK_HZ        = 50_000_000;
    localparam int          TCU_STEP_SLOW_MS  = 100;
    localparam int          TCU_STEP_FAST_MS  = 10;
    localparam int          TCU_STEP_SLOW_CYC = TCU_CLK_HZ / 1000 * TCU_STEP_SLOW_MS;
    localparam int          TCU_STEP_FAST_CYC = TCU_CLK_HZ / 1000 * TCU_STEP_FAST_MS;
    localparam logic [7:0]  TCU_INIT_CYCLES   = 8'h10;

    localparam logic [63:0] TCU_ACCUM_MASK    = 64'hc000_c000_0000_0000;
    localparam logic [63:0] TCU_FAST_MASK     = 64'hffff_0000_0000_0000;

    localparam logic [7:0]  TCU_OFS_CFG       = 8'h00;
    localparam logic [7:0]  TCU_OFS_FLAGS     = 8'h04;
    localparam logic [7:0]  TCU_OFS_HWC0      = 8'h08;
    localparam logic [7:0]  TCU_OFS_HWC1      = 8'h0c;
    localparam logic [7:0]  TCU_OFS_INPUTS    = 8'h10;
    localparam logic [7:0]  TCU_OFS_ACTIVE    = 8'h14;
    localparam logic [15:0] TCU_CFG_RST       = 16'h0000;
    localparam int          TCU_FLAG_READY    = 0;
    localparam int          TCU_FLAG_FAULT    = 1;
    localparam int          TCU_FLAG_REBOOT   = 2;
    localparam logic [3:0]  TCU_CFG_MAX       = 4'hc;

    typedef enum logic [0:0] {TCU_INIT, TCU_RUN} tcu_phase_type;

    // edge select: {quad, c0 rise, c0 fall, c1 rise, c1 fall}
    function automatic logic [4:0] tcu_edge_sel(input logic [3:0] cfg);
        logic [4:0] s;
        s = 5'h00;
        unique case (cfg)
            4'h1:    s = 5'h08;
            4'h2:    s = 5'h04;
            4'h3:    s = 5'h0c;
            4'h4:    s = 5'h02;
            4'h5:    s = 5'h01;
            4'h6:    s = 5'h0a;
            4'h7:    s = 5'h06;
            4'h8:    s = 5'h0e;
            4'h9:    s = 5'h09;
            4'ha:    s = 5'h05;
            4'hb:    s = 5'h0d;
            4'hc:    s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction : tcu_edge_sel

    typedef struct packed {
        logic [63:0][15:0] tval;
        logic [63:0][15:0] tpre;
        logic [63:0]       trun;
        logic [63:0]       tdone;
        logic [63:0][31:0] cval;
        logic [63:0]       cprev;
        logic [63:0]       cdone;
        logic [31:0]       hwc0;
        logic [31:0]       hwc1;
        logic [2:0]        sy0;
        logic [2:0]        sy1;
        logic [7:0]        image;
        logic [7:0]        irql;
        logic [15:0]       cfg;
        logic [3:0]        acfg;
        logic              ready;
        logic              fault;
        logic              rebreq;
        logic              reboot;
        tcu_phase_type     phase;
        logic [7:0]        init_cnt;
        logic [31:0]       slow_cnt;
        logic [31:0]       fast_cnt;
        logic              wpend;
        logic [7:0]        waddr;
        logic [31:0]       rdata;
    } tcu_state_type;

    localparam tcu_state_type TCU_STATE_RST = '0;

endpackage : tcu_pkg

`default_nettype wire

// [design/tcu_timer_counter.sv]
// plc timer / counter unit: 64 timers, 64 scan counters, two pin counters, special flags.
// assumes a scan engine issuing one-cycle instruction strobes, pins synchronous to clk
// except the two counter pins, and one ahb-lite master.

`default_nettype none

module tcu_timer_counter
    import tcu_pkg::*;
#(
    parameter int SLOW_STEP_CYC = TCU_STEP_SLOW_CYC,
    parameter int FAST_STEP_CYC = TCU_STEP_FAST_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  input_pins,
    input  wire logic        scan_start,
    input  wire logic        irq_service,
    input  wire logic [2:0]  irq_index,
    input  wire logic        tmr_exec,
    input  wire logic [5:0]  tmr_index,
    input  wire logic        tmr_enable,
    input  wire logic        tmr_preset_sel,
    input  wire logic [15:0] tmr_preset_const,
    input  wire logic [15:0] tmr_preset_dreg,
    input  wire logic        cnt_exec,
    input  wire logic [5:0]  cnt_index,
    input  wire logic        cnt_input,
    input  wire logic [15:0] cnt_preset,
    input  wire logic        rst_exec,
    input  wire logic        rst_timer,
    input  wire logic [6:0]  rst_index,
    output logic      [63:0] timer_contact,
    output logic      [63:0] counter_contact,
    output logic      [31:0] hw_pulse_counter_0,
    output logic      [31:0] hw_pulse_counter_1,
    output logic      [7:0]  input_image,
    output logic      [7:0]  irq_input_latch,
    output logic             periph_ready_flag,
    output logic             periph_init_busy,
    output logic             fault_lamp_out,
    output logic             sys_reboot
);

    tcu_state_type st_reg;
    tcu_state_type st_next;

    logic        addr_ok;
    logic        slow_tick;
    logic        fast_tick;
    logic [4:0]  esel;
    logic        rise0;
    logic        fall0;
    logic        rise1;
    logic        fall1;
    logic        wr_flags;
    logic        wr_ready_clear;

    assign addr_ok   = hsel && htrans[1] && hready;
    assign slow_tick = (st_reg.slow_cnt == 32'(SLOW_STEP_CYC - 1));
    assign fast_tick = (st_reg.fast_cnt == 32'(FAST_STEP_CYC - 1));
    assign esel      = tcu_edge_sel(st_reg.acfg);
    // edges come from the second and third stages only; stage one feeds stage two alone
    assign rise0     = st_reg.sy0[1] && !st_reg.sy0[2];
    assign fall0     = !st_reg.sy0[1] && st_reg.sy0[2];
    assign rise1     = st_reg.sy1[1] && !st_reg.sy1[2];
    assign fall1     = !st_reg.sy1[1] && st_reg.sy1[2];
    assign wr_flags  = st_reg.wpend && (st_reg.waddr == TCU_OFS_FLAGS);
    assign wr_ready_clear = wr_flags && !hwdata[TCU_FLAG_READY] && st_reg.ready;

    // quadrature step: +1 forward, -1 reverse, 0 for no move or a skipped state
    function automatic logic [31:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case ({prev, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: d = 32'h0000_0001;
            4'b1000, 4'b1110, 4'b0111, 4'b0001: d = 32'hffff_ffff;
            default:                            d = 32'h0000_0000;
        endcase
        return d;
    endfunction : quad_step

    always_comb begin
        logic [15:0] preset;
        preset  = tmr_preset_sel ? tmr_preset_dreg : tmr_preset_const;
        st_next = st_reg;
        st_next.reboot = 1'b0;

        // step bases for both timer resolutions
        st_next.slow_cnt = slow_tick ? 32'h0 : st_reg.slow_cnt + 32'h1;
        st_next.fast_cnt = fast_tick ? 32'h0 : st_reg.fast_cnt + 32'h1;

        for (int i = 0; i < 64; i++) begin
            if (st_reg.trun[i] && (TCU_FAST_MASK[i] ? fast_tick : slow_tick)
                && (st_reg.tval[i] < st_reg.tpre[i])) begin
                st_next.tval[i] = st_reg.tval[i] + 16'h0001;
            end
            if (st_reg.trun[i] && (st_next.tval[i] >= st_reg.tpre[i])) begin
                st_next.tdone[i] = 1'b1;
            end
        end

        // timer instruction acts in the same cycle it is issued
        if (tmr_exec) begin
            st_next.tpre[tmr_index] = preset;
            st_next.trun[tmr_index] = tmr_enable;
            if (tmr_enable) begin
                st_next.tdone[tmr_index] = (st_next.tval[tmr_index] >= preset);
            end else if (!TCU_ACCUM_MASK[tmr_index]) begin
                st_next.tval[tmr_index]  = 16'h0000;
                st_next.tdone[tmr_index] = 1'b0;
            end
            // accumulative timers simply stop and keep value and contact
        end

        // scan counter: counts rising edges of the value the program feeds it
        if (cnt_exec) begin
            if (cnt_input && !st_reg.cprev[cnt_index] && !st_reg.cdone[cnt_index]) begin
                st_next.cval[cnt_index] = st_reg.cval[cnt_index] + 32'h1;
            end
            if (!st_reg.cdone[cnt_index]) begin
                st_next.cdone[cnt_index] =
                    (st_next.cval[cnt_index] >= {16'h0, cnt_preset});
            end
            st_next.cprev[cnt_index] = cnt_input;
        end

        // reset instruction overrides a same-cycle count or timer instruction
        if (rst_exec) begin
            if (rst_timer) begin
                st_next.tval[rst_index[5:0]]  = 16'h0000;
                st_next.tdone[rst_index[5:0]] = 1'b0;
                st_next.trun[rst_index[5:0]]  = 1'b0;
            end else if (!rst_index[6]) begin
                st_next.cval[rst_index[5:0]]  = 32'h0;
                st_next.cdone[rst_index[5:0]] = 1'b0;
            end else if (rst_index[0]) begin
                st_next.hwc1 = 32'h0;
            end else begin
                st_next.hwc0 = 32'h0;
            end
        end

        // pin counters: synchronise, then count edges regardless of the scan
        st_next.sy0 = {st_reg.sy0[1], st_reg.sy0[0], input_pins[0]};
        st_next.sy1 = {st_reg.sy1[1], st_reg.sy1[0], input_pins[1]};
        if (esel[4]) begin
            st_next.hwc0 = st_next.hwc0 + quad_step({st_reg.sy0[2], st_reg.sy1[2]},
                                                    {st_reg.sy0[1], st_reg.sy1[1]});
        end else if ((esel[3] && rise0) || (esel[2] && fall0)) begin
            st_next.hwc0 = st_next.hwc0 + 32'h1;
        end
        if ((esel[1] && rise1) || (esel[0] && fall1)) begin
            st_next.hwc1 = st_next.hwc1 + 32'h1;
        end

        // image sampled only at scan start; pins given to a counter read as zero
        if (scan_start) begin
            st_next.image    = input_pins;
            st_next.image[0] = input_pins[0] && !(esel[4] || |esel[3:2]);
            st_next.image[1] = input_pins[1] && !(esel[4] || |esel[1:0]);
        end
        if (irq_service) begin
            st_next.irql[irq_index] = input_pins[irq_index];
        end

        // peripheral init sequencing
        unique case (st_reg.phase)
            TCU_INIT: begin
                st_next.init_cnt = st_reg.init_cnt + 8'h01;
                if (st_reg.init_cnt == TCU_INIT_CYCLES - 8'h01) begin
                    st_next.phase    = TCU_RUN;
                    st_next.ready    = 1'b1;
                    st_next.init_cnt = 8'h00;
                    st_next.hwc0     = 32'h0;
                    st_next.hwc1     = 32'h0;
                    // out-of-range settings fall back to plain inputs
                    st_next.acfg = (st_reg.cfg > {12'h0, TCU_CFG_MAX}) ?
                                   4'h0 : st_reg.cfg[3:0];
                end
            end
            TCU_RUN: begin
                if (wr_ready_clear) begin
                    st_next.phase = TCU_INIT;
                    st_next.ready = 1'b0;
                    if (st_reg.rebreq) begin
                        st_next.reboot = 1'b1;
                        st_next.rebreq = 1'b0;
                        st_next.fault  = 1'b0;
                    end
                end
            end
        endcase

        // ahb-lite data phase of a write
        st_next.wpend = 1'b0;
        if (st_reg.wpend) begin
            if (st_reg.waddr == TCU_OFS_CFG) begin
                st_next.cfg = hwdata[15:0];
            end
            if (wr_flags) begin
                st_next.fault = hwdata[TCU_FLAG_FAULT];
                if (!st_next.reboot) begin
                    st_next.rebreq = hwdata[TCU_FLAG_REBOOT];
                end
            end
        end

        // ahb-lite address phase: reads are registered here, writes wait for hwdata
        if (addr_ok && hwrite && haddr[31:8] == 24'h0) begin
            st_next.wpend = 1'b1;
            st_next.waddr = haddr[7:0];
        end
        if (addr_ok && !hwrite) begin
            if (haddr[31:8] != 24'h0) begin
                st_next.rdata = 32'h0;
            end else begin
                unique case (haddr[7:0])
                    TCU_OFS_CFG:    st_next.rdata = {16'h0, st_reg.cfg};
                    TCU_OFS_FLAGS:  st_next.rdata = {29'h0, st_reg.rebreq, st_reg.fault,
                                                     st_reg.ready};
                    TCU_OFS_HWC0:   st_next.rdata = st_reg.hwc0;
                    TCU_OFS_HWC1:   st_next.rdata = st_reg.hwc1;
                    TCU_OFS_INPUTS: st_next.rdata = {16'h0, st_reg.irql, st_reg.image};
                    TCU_OFS_ACTIVE: st_next.rdata = {27'h0, st_reg.phase == TCU_INIT,
                                                     st_reg.acfg};
                    default:        st_next.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= TCU_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // zero wait states: every transfer completes in its first data-phase cycle
    assign hrdata             = st_reg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign timer_contact      = st_reg.tdone;
    assign counter_contact    = st_reg.cdone;
    assign hw_pulse_counter_0 = st_reg.hwc0;
    assign hw_pulse_counter_1 = st_reg.hwc1;
    assign input_image        = st_reg.image;
    assign irq_input_latch    = st_reg.irql;
    assign periph_ready_flag  = st_reg.ready;
    assign periph_init_busy   = (st_reg.phase == TCU_INIT);
    assign fault_lamp_out     = st_reg.fault;
    assign sys_reboot         = st_reg.reboot;

    // helpers for the checks below
    logic        pin_at_irq;
    logic [31:0] cval_at_cnt;
    logic        cdone_at_cnt;
    logic        tmr_clear_req;
    logic        tmr_reached;
    assign pin_at_irq    = input_pins[irq_index];
    assign cval_at_cnt   = st_reg.cval[cnt_index];
    assign cdone_at_cnt  = st_reg.cdone[cnt_index];
    assign tmr_clear_req = tmr_exec && !tmr_enable && !TCU_ACCUM_MASK[tmr_index] && !rst_exec;
    assign tmr_reached   = st_reg.trun[tmr_index]
                           && (st_reg.tval[tmr_index] >= st_reg.tpre[tmr_index]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_irq_latch;
        irq_service |=> irq_input_latch[$past(irq_index)] == $past(pin_at_irq);
    endproperty
    a_irq_latch: assert property (p_irq_latch) else $error("irq latch missed pin");

    property p_image_hold;
        !scan_start |=> $stable(input_image);
    endproperty
    a_image_hold: assert property (p_image_hold) else $error("image moved mid scan");

    property p_ready_hold;
        periph_ready_flag && !wr_ready_clear |=> periph_ready_flag;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped alone");

    sequence s_ready_cleared;
        wr_ready_clear ##1 !periph_ready_flag;
    endsequence
    property p_reinit;
        s_ready_cleared |-> periph_init_busy ##[1:20] periph_ready_flag;
    endproperty
    a_reinit: assert property (p_reinit) else $error("init did not rerun");

    property p_fault_lamp;
        wr_flags && !wr_ready_clear |=> fault_lamp_out == $past(hwdata[TCU_FLAG_FAULT]);
    endproperty
    a_fault_lamp: assert property (p_fault_lamp) else $error("fault lamp wrong");

    property p_reboot;
        wr_ready_clear && st_reg.rebreq |=> sys_reboot ##1 !sys_reboot;
    endproperty
    a_reboot: assert property (p_reboot) else $error("reboot not pulsed");

    property p_tmr_clear;
        tmr_clear_req |=> !timer_contact[$past(tmr_index)];
    endproperty
    a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared");

    property p_cnt_hold;
        cnt_exec && cdone_at_cnt && !rst_exec
            |=> st_reg.cval[$past(cnt_index)] == $past(cval_at_cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved past preset");

    property p_cnt_reset;
        rst_exec && !rst_timer && !rst_index[6]
            |=> !counter_contact[$past(rst_index[5:0])]
                && st_reg.cval[$past(rst_index[5:0])] == 32'h0;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("counter reset failed");

    property p_cfg0_idle;
        st_reg.acfg == 4'h0 && periph_ready_flag && !rst_exec |=> $stable(hw_pulse_counter_0);
    endproperty
    a_cfg0_idle: assert property (p_cfg0_idle) else $error("counter ran in cfg 0");

    property p_rise_count;
        st_reg.acfg == 4'h1 && rise0 && periph_ready_flag && !rst_exec
            |=> hw_pulse_counter_0 == $past(hw_pulse_counter_0) + 32'h1;
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("rising edge not counted");

    property p_hwc1_rise;
        st_reg.acfg == 4'h4 && rise1 && periph_ready_flag && !rst_exec
            |=> hw_pulse_counter_1 == $past(hw_pulse_counter_1) + 32'h1;
    endproperty
    a_hwc1_rise: assert property (p_hwc1_rise) else $error("counter 1 edge missed");

    property p_quad_step;
        st_reg.acfg == 4'hc && periph_ready_flag && !rst_exec
            |=> hw_pulse_counter_0 - $past(hw_pulse_counter_0) + 32'h1 <= 32'h2;
    endproperty
    a_quad_step: assert property (p_quad_step) else $error("quadrature jumped");

    property p_sync_delay;
        rise0 |-> $past(input_pins[0], 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("edge too early");

    property p_tmr_start;
        tmr_exec && tmr_enable && !rst_exec |=> st_reg.trun[$past(tmr_index)];
    endproperty
    a_tmr_start: assert property (p_tmr_start) else $error("timer did not start");

    property p_tmr_contact;
        tmr_reached && !tmr_exec && !rst_exec |=> timer_contact[$past(tmr_index)];
    endproperty
    a_tmr_contact: assert property (p_tmr_contact) else $error("timer contact open");

    property p_image_sample;
        scan_start |=> input_image[7:2] == $past(input_pins[7:2]);
    endproperty
    a_image_sample: assert property (p_image_sample) else $error("image not sampled");

endmodule : tcu_timer_counter

`default_nettype wire
